// File: rtl/liem_chan.sv
// liem_chan: one channel's edge select, masks, flags and request
// assumes: decode of the channel window done by the top; wr/rd one cycle
`timescale 1ns/10ps
`default_nettype none
module liem_chan
   import liem_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register access, already decoded to this channel
   input wire logic sel,
   input wire liem_req_s req,
   // detectors
   input wire liem_chan_in_s det,
   // results
   output logic [DATA_W-1:0] rdata,
   output logic hit,
   output logic irq
);
   logic [DATA_W-1:0] edge_sel_q;
   logic [DATA_W-1:0] mask0_q;
   logic [DATA_W-1:0] mask1_q;
   logic [DATA_W-1:0] flags0_q;
   logic [DATA_W-1:0] flags0_d;
   logic [DATA_W-1:0] flags1_q;
   logic [DATA_W-1:0] flags1_d;
   logic [DATA_W-1:0] any0;
   logic [DATA_W-1:0] any1;
   logic [DATA_W-1:0] set0;
   logic [DATA_W-1:0] set1;
   logic [DATA_W-1:0] clr0;
   logic [DATA_W-1:0] clr1;
   logic [5:0] ofs;
   logic wr_es;
   logic wr_m0;
   logic wr_m1;
   logic rd_f0;
   logic rd_f1;

   // ------------------------------------------------------------
   // edge mode per status bit
   // ------------------------------------------------------------
   assign any0 = {3'b000,
                  edge_sel_q[ES_OVC],
                  edge_sel_q[ES_TXCLK],
                  edge_sel_q[ES_TXSIL],
                  edge_sel_q[ES_RXSIL],
                  edge_sel_q[ES_RXSIL]};
   assign any1 = {edge_sel_q[ES_ALARM],
                  edge_sel_q[ES_ALARM],
                  edge_sel_q[ES_PRBS],
                  3'b000,
                  edge_sel_q[ES_LOOP],
                  edge_sel_q[ES_LOOP]};

   // one detector per status bit; unused word 1 positions are gated off below, unused word 0 positions take pulse0
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_bit
         logic s0;
         logic s1;
         liem_edge_detect u_e0 (
            .clk(clk),
            .rstn(rstn),
            .state(det.status_word_0[gi]),
            .any_edge(any0[gi]),
            .set_pulse(s0)
         );
         liem_edge_detect u_e1 (
            .clk(clk),
            .rstn(rstn),
            .state(det.status_word_1[gi]),
            .any_edge(any1[gi]),
            .set_pulse(s1)
         );
         assign set0[gi] = ST0_USED[gi] ? s0 : det.pulse0[gi];
         assign set1[gi] = ST1_USED[gi] & s1;
      end
   endgenerate

   // ------------------------------------------------------------
   // access decode; flags clear on read, a set in the same cycle wins
   // ------------------------------------------------------------
   assign ofs = req.addr[5:0];
   assign wr_es = sel & req.wr & (ofs == OFS_EDGE_SEL);
   assign wr_m0 = sel & req.wr & (ofs == OFS_MASK0);
   assign wr_m1 = sel & req.wr & (ofs == OFS_MASK1);
   assign rd_f0 = sel & req.rd & (ofs == OFS_FLAGS0);
   assign rd_f1 = sel & req.rd & (ofs == OFS_FLAGS1);
   assign clr0 = rd_f0 ? flags0_q : ZERO8;
   assign clr1 = rd_f1 ? flags1_q : ZERO8;
   assign flags0_d = (flags0_q & ~clr0) | set0;
   assign flags1_d = (flags1_q & ~clr1) | set1;

   // registers of this channel
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         edge_sel_q <= EDGE_SEL_RST;
         mask0_q <= MASK0_RST;
         mask1_q <= MASK1_RST;
         flags0_q <= ZERO8;
         flags1_q <= ZERO8;
      end else begin
         if (wr_es) edge_sel_q <= req.wdata & ES_WMASK;
         if (wr_m0) mask0_q <= req.wdata;
         if (wr_m1) mask1_q <= req.wdata & M1_WMASK;
         flags0_q <= flags0_d;
         flags1_q <= flags1_d;
      end
   end

   // read mux; hit marks an implemented offset
   always_comb begin
      rdata = ZERO8;
      hit = 1'b1;
      unique case (ofs)
         OFS_EDGE_SEL: rdata = edge_sel_q;
         OFS_MASK0: rdata = mask0_q;
         OFS_MASK1: rdata = mask1_q;
         OFS_STATUS0: rdata = det.status_word_0 & ST0_USED;
         OFS_STATUS1: rdata = det.status_word_1 & ST1_USED;
         OFS_FLAGS0: rdata = flags0_q;
         OFS_FLAGS1: rdata = flags1_q;
         default: hit = 1'b0;
      endcase
   end

   // a masked flag still latches but requests nothing
   assign irq = |(flags0_q & ~mask0_q) | |(flags1_q & ~mask1_q);
endmodule // liem_chan
`default_nettype wire

// File: rtl/liem_edge_detect.sv
// liem_edge_detect: one bit of status, turned into a set pulse by edge select
// assumes: state input already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module liem_edge_detect
   import liem_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // status and mode
   input wire logic state,
   input wire logic any_edge,
   // result
   output logic set_pulse
);
   logic prev_q;

   // previous level; reset to idle so a state high at reset counts as a rise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= state;
      end
   end

   // rise always counts, fall only in any-edge mode
   assign set_pulse = (state & ~prev_q) | (any_edge & ~state & prev_q);
endmodule // liem_edge_detect
`default_nettype wire

// File: rtl/liem_pkg.sv
// liem_pkg: constants and carrier types for the per-channel alarm edge/mask block
// assumes: one clock domain, registers reached over a plain strobe port
package liem_pkg;

   // ------------------------------------------------------------
   // channel map
   // ------------------------------------------------------------
   localparam int unsigned NUM_CH = 22;
   localparam int unsigned CH_W = 5;
   localparam int unsigned ADDR_W = 11;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] CH_STRIDE = 11'h040;
   localparam logic [ADDR_W-1:0] CH0_BASE = 11'h7C0;
   localparam logic [5:0] OFS_MASK = 6'h3F;

   // ------------------------------------------------------------
   // register offsets inside a channel window
   // ------------------------------------------------------------
   localparam logic [5:0] OFS_EDGE_SEL = 6'h1A;
   localparam logic [5:0] OFS_MASK0 = 6'h1B;
   localparam logic [5:0] OFS_MASK1 = 6'h1C;
   localparam logic [5:0] OFS_STATUS0 = 6'h1E;
   localparam logic [5:0] OFS_STATUS1 = 6'h1F;
   localparam logic [5:0] OFS_FLAGS0 = 6'h20;
   localparam logic [5:0] OFS_FLAGS1 = 6'h21;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] EDGE_SEL_RST = 8'h00;
   localparam logic [DATA_W-1:0] MASK0_RST = 8'hFF;
   localparam logic [DATA_W-1:0] MASK1_RST = 8'hE3;
   localparam logic [DATA_W-1:0] ZERO8 = 8'h00;

   // ------------------------------------------------------------
   // edge select bit positions
   // ------------------------------------------------------------
   localparam int unsigned ES_LOOP = 0;
   localparam int unsigned ES_RXSIL = 1;
   localparam int unsigned ES_TXSIL = 2;
   localparam int unsigned ES_TXCLK = 3;
   localparam int unsigned ES_OVC = 4;
   localparam int unsigned ES_PRBS = 5;
   localparam int unsigned ES_ALARM = 6;
   localparam logic [DATA_W-1:0] ES_WMASK = 8'h7F;
   localparam logic [DATA_W-1:0] M1_WMASK = 8'hE3;

   // ------------------------------------------------------------
   // event word 0 / word 1 bit positions
   // ------------------------------------------------------------
   localparam int unsigned B0_LINE_SIL = 0;
   localparam int unsigned B0_SYS_SIL = 1;
   localparam int unsigned B0_TX_SIL = 2;
   localparam int unsigned B0_TX_CLK = 3;
   localparam int unsigned B0_OVC = 4;
   localparam int unsigned B0_RX_JIT = 5;
   localparam int unsigned B0_TX_JIT = 6;
   localparam int unsigned B0_AMP = 7;
   localparam int unsigned B1_DEACT = 0;
   localparam int unsigned B1_ACT = 1;
   localparam int unsigned B1_PRBS = 5;
   localparam int unsigned B1_LALARM = 6;
   localparam int unsigned B1_SALARM = 7;
   localparam logic [DATA_W-1:0] ST0_USED = 8'h1F;
   localparam logic [DATA_W-1:0] ST1_USED = 8'hE3;

   // per-channel detector levels and pulse events
   typedef struct packed {
      logic [DATA_W-1:0] status_word_0; // levels: line/sys/tx silence, tx clk missing, overcurrent
      logic [DATA_W-1:0] status_word_1; // levels: deact, act, prbs lock, line/sys alarm
      logic [DATA_W-1:0] pulse0; // pulses: rx jitter fifo, tx jitter fifo, amplitude
   } liem_chan_in_s;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } liem_req_s;

endpackage : liem_pkg

// File: rtl/liem_top.sv
// liem_top: interrupt edge select and mask front end for 22 line channels
// assumes: detector inputs and register strobes synchronous to clk
//
// Notes on behaviour
// - alarm select 0: rising line/system alarm sets flag; 1: any change
// - prbs lock select 0: rising change sets flag; 1: any change
// - overcurrent select 0: rising change sets flag; 1: any change
// - tx clock missing select 0: rising sets flag; 1: any change
// - tx silence select 0: rising sets flag; 1: any change
// - one rx silence select drives line and system silence flags
// - one loop code select drives activate and deactivate code flags
// - mask bit 7 gates amplitude overflow, 1 masks, reset masked
// - mask bit 6 gates tx jitter fifo event, reset masked
// - mask bit 5 gates rx jitter fifo event, reset masked
// - mask bit 4 gates overcurrent, reset masked
// - mask bit 3 gates tx clock missing, reset masked
// - mask bit 2 gates tx silence, reset masked
// - mask bit 1 gates system silence, reset masked
// - mask bit 0 gates line silence, reset masked
// - 22 channels at stride 0x40, channel 0 high; edge select and masks read/write, status and flags read only
`timescale 1ns/10ps
`default_nettype none
module liem_top
   import liem_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // detectors, one entry per channel
   input wire liem_chan_in_s [NUM_CH-1:0] det,
   // interrupt requests
   output logic [NUM_CH-1:0] chan_irq,
   output logic irq
);
   liem_req_s req;
   logic [CH_W-1:0] ch_idx;
   logic ch_valid;
   logic [DATA_W-1:0] ch_rdata [NUM_CH];
   logic [NUM_CH-1:0] ch_hit;
   logic [NUM_CH-1:0] ch_irq;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] rdata_q;
   logic [NUM_CH-1:0] chan_irq_q;
   logic irq_q;
   logic [CH_W-1:0] blk;
   logic blk_is_ch0;
   logic blk_is_line;
   // window number of an address; line channel n lives in window n-1
   localparam int unsigned BLK_LSB = ADDR_W - CH_W;
   localparam logic [CH_W-1:0] CH0_BLK = CH0_BASE[ADDR_W-1:BLK_LSB];
   localparam logic [CH_W-1:0] LINE_BLKS = CH_W'(NUM_CH - 1);
   localparam logic [CH_W-1:0] BLK_STEP = CH_W'(1);

   // ------------------------------------------------------------
   // address decode: channels 1..21 from window zero up, channel 0 at the top
   // ------------------------------------------------------------
   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign blk = addr[ADDR_W-1:BLK_LSB];
   assign blk_is_ch0 = (blk == CH0_BLK);
   assign blk_is_line = (blk < LINE_BLKS);
   assign ch_valid = blk_is_ch0 | blk_is_line;
   // index stays in range even for unmapped windows, so the read mux never strays
   assign ch_idx = blk_is_line ? (blk + BLK_STEP) : '0;

   // one channel slice per line
   genvar gc;
   generate
      for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
         liem_chan u_chan (
            .clk(clk),
            .rstn(rstn),
            .sel(ch_valid & (ch_idx == CH_W'(gc))),
            .req(req),
            .det(det[gc]),
            .rdata(ch_rdata[gc]),
            .hit(ch_hit[gc]),
            .irq(ch_irq[gc])
         );
      end
   endgenerate

   // unmapped addresses read zero; writes there are dropped
   assign rdata_d = (rd & ch_valid & ch_hit[ch_idx]) ? ch_rdata[ch_idx] : ZERO8;

   // read data one cycle after the strobe, and only then
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= ZERO8;
         chan_irq_q <= '0;
         irq_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         chan_irq_q <= ch_irq;
         irq_q <= |ch_irq;
      end
   end

   assign rdata = rdata_q;
   assign chan_irq = chan_irq_q;
   assign irq = irq_q;
endmodule // liem_top
`default_nettype wire

// File: sim/liem_top_monitor.sv
// liem_top_monitor: port-level checks for the alarm edge/mask block
// assumes: bound to liem_top, one clock, async active-low reset
`timescale 1ns/10ps
`default_nettype none
module liem_top_monitor
   import liem_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   // detectors and requests
   input wire liem_chan_in_s [NUM_CH-1:0] det,
   input wire logic [NUM_CH-1:0] chan_irq,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // no mask can open before the first write, so requests stay low
   logic wrote_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wrote_q <= 1'b0;
      else if (wr) wrote_q <= 1'b1;
   end
   sequence s_es_wr; wr && addr == 11'h01A; endsequence
   sequence s_es_rd; rd && addr == 11'h01A; endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00) else $error("read data not zero");
   a_edge_sel_back: assert property (s_es_wr ##1 s_es_rd |=> rdata == ($past(wdata, 2) & 8'h7F))
      else $error("edge select readback wrong");
   a_es_bit7_zero: assert property (rd && addr[5:0] == 6'h1A |=> !rdata[7]) else $error("reserved bit set");
   a_unmapped_zero: assert property (rd && addr[5:0] == 6'h00 |=> rdata == 8'h00) else $error("unmapped read");
   a_status_direct: assert property (rd && addr == 11'h7DE |=> rdata == ($past(det[0].status_word_0) & 8'h1F))
      else $error("status read wrong");
   a_irq_is_or: assert property (irq == (|chan_irq)) else $error("irq not or of channels");
   a_quiet_after_rst: assert property ($rose(rstn) |-> !irq ##1 !irq) else $error("irq after reset");
   a_masked_default: assert property (!wrote_q |-> chan_irq == '0) else $error("request while masked");
endmodule // liem_top_monitor
bind liem_top liem_top_monitor u_mon (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .det(det), .chan_irq(chan_irq), .irq(irq));
`default_nettype wire

// File: sim/test_liem_top.sv
// test_liem_top: directed bench for the alarm edge/mask block
// assumes: liem_top alone, bench drives register port and detectors
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_liem_top
   import liem_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   liem_chan_in_s [NUM_CH-1:0] det = '0;
   logic [NUM_CH-1:0] chan_irq;
   logic irq;
   int err_total = 0;
   int samples_checked = 0;
   // 200 MHz
   always #2.5 clk = ~clk;
   liem_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .det(det), .chan_irq(chan_irq), .irq(irq));
   // ------------------------------------------------------------
   // bus and detector helpers
   // ------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] ra(int ch, logic [5:0] ofs);
      ra = (ch == 0) ? {CH0_BASE[10:6], ofs} : {5'(ch - 1), ofs};
   endfunction
   task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // b2b skips the idle edge so a read may follow a write directly
   task automatic chk_rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e, bit b2b = 0);
      if (!b2b) @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(rdata, e)
   endtask
   task automatic set_det(int ch, logic [7:0] s0, logic [7:0] s1, logic [7:0] p0);
      @(posedge clk);
      det[ch] <= {s0, s1, p0};
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      chk_rd(ra(0, OFS_EDGE_SEL), 8'h00);
      for (int ch = 0; ch < NUM_CH; ch++) begin
         chk_rd(ra(ch, OFS_MASK0), 8'hFF);
         wr_reg(ra(ch, OFS_MASK0), 8'(ch));
         wr_reg(ra(ch, OFS_EDGE_SEL), 8'hC0 | 8'(ch));
         chk_rd(ra(ch, OFS_EDGE_SEL), 8'h40 | 8'(ch), 1);
         chk_rd(ra(ch, OFS_MASK0), 8'(ch));
      end
      chk_rd(11'h000, 8'h00);
      $display("t_regs done");
   endtask
   // every edge select, rising then falling, with all masks closed
   task automatic t_edges();
      logic [7:0] b;
      wr_reg(ra(3, OFS_MASK0), 8'hFF);
      for (int s = 0; s < 2; s++) begin
         wr_reg(ra(3, OFS_EDGE_SEL), s ? 8'h7F : 8'h00);
         for (int w = 0; w < 2; w++) for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            if ((b & (w ? ST1_USED : ST0_USED)) != 8'h00) begin
               set_det(3, w ? 8'h00 : b, w ? b : 8'h00, 8'h00);
               repeat (3) @(posedge clk);
               chk_rd(ra(3, w ? OFS_FLAGS1 : OFS_FLAGS0), b);
               set_det(3, 8'h00, 8'h00, 8'h00);
               repeat (3) @(posedge clk);
               chk_rd(ra(3, w ? OFS_FLAGS1 : OFS_FLAGS0), s ? b : 8'h00);
            end
         end
      end
      `CHK(irq, 1'b0)
      $display("t_edges done");
   endtask
   // a masked flag latches silently and requests once its bit opens
   task automatic t_masks();
      logic [7:0] b;
      wr_reg(ra(5, OFS_EDGE_SEL), 8'h00);
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         wr_reg(ra(5, OFS_MASK0), 8'hFF);
         set_det(5, i < 5 ? b : 8'h00, 8'h00, i < 5 ? 8'h00 : b);
         set_det(5, i < 5 ? b : 8'h00, 8'h00, 8'h00);
         repeat (4) @(posedge clk);
         `CHK(irq, 1'b0)
         wr_reg(ra(5, OFS_MASK0), ~b);
         repeat (3) @(posedge clk);
         `CHK(chan_irq, 22'h000020)
         `CHK(irq, 1'b1)
         chk_rd(ra(5, OFS_FLAGS0), b);
         set_det(5, 8'h00, 8'h00, 8'h00);
         repeat (3) @(posedge clk);
         `CHK(chan_irq, 22'h000000)
      end
      $display("t_masks done");
   endtask
   // status reads show detector levels; an unmapped window ignores writes
   task automatic t_status();
      set_det(0, 8'hFF, 8'hFF, 8'h00);
      chk_rd(ra(0, OFS_STATUS0), 8'h1F);
      chk_rd(ra(0, OFS_STATUS1), 8'hE3);
      repeat (2) @(posedge clk);
      `CHK(chan_irq, 22'h000001)
      wr_reg(11'h55A, 8'h7F);
      chk_rd(11'h55A, 8'h00);
      $display("t_status done");
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_edges();
      t_masks();
      t_status();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test();
   end
endmodule // test_liem_top
`default_nettype wire
